// ---- src/interrupt_vector_priority_unit.sv ----
// Interrupt arbitration and vectoring unit for the microcontroller core
//
// What this block does
// - Sample flags, resolve priority every clock
// - Best case: detect 1, call 4 cycles
// - After return, one instruction before call
// - Worst case eighteen cycles after return
// - Equal or higher active routine holds request
// - Fixed vectors eight apart, list order tiebreak
// - Auto-clear ext and timer0/1 flags
// - Global gate zero blocks every source
// - Mask register bits five to zero
// - Timer2 requests on either wrap flag
// - Bit six is plain storage
// - Level register bits, one selects high
// - Level register top bits read ones
// - High preempts low, never high
// - Extra mask register, top bits zero
// - Extra level register, top bits ones
`timescale 1ns/1ns

module interrupt_vector_priority_unit #(
   parameter int NUM_SRC = ivpu_pkg::NUM_SOURCES
) (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire ivpu_pkg::pending_type pending_i, // Peripheral pending flags
   input wire ivpu_pkg::sfr_req_type sfr_i, // Register write port from the core
   input wire ivpu_pkg::core_status_type core_i, // Instruction boundary status
   output logic [7:0] sfr_rdata_o, // Registered read data of addressed register
   output logic call_o, // Forced call in progress
   output logic [15:0] vector_o, // Call target address
   output logic [11:0] flag_clear_o, // One-cycle clear pulse to pending flags
   output logic active_high_o, // High level routine active
   output logic active_low_o // Low level routine active
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] int_mask_reg;
      logic [5:0] int_level_reg;
      logic [5:0] extra_mask_reg;
      logic [5:0] extra_level_reg;
      logic req_valid;
      logic [3:0] req_idx;
      ivpu_pkg::call_state_type state;
      logic [2:0] call_cnt;
      logic act_hi;
      logic act_lo;
      logic [7:0] rdata;
      logic [15:0] vector;
      logic [11:0] flag_clear;
   } state_type;

   state_type cur_reg;
   state_type cur_next;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Lowest index wins inside a level; high level searched last, so it overrides low
   function automatic logic [4:0] pick_winner(input logic [NUM_SRC-1:0] req,
                                              input logic [NUM_SRC-1:0] lvl,
                                              input logic lo_ok);
      logic [4:0] res;
      res = 5'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (lo_ok && req[i] && !lvl[i]) begin
            res = {1'b1, 4'(i)};
         end
      end
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i] && lvl[i]) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction

   function automatic logic [15:0] vector_of(input logic [3:0] idx);
      return ivpu_pkg::FIRST_VECTOR + 16'(ivpu_pkg::VECTOR_STEP * 16'(idx));
   endfunction

   // ----------------------------------------------------------------
   // Request gathering
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] flags;
   logic [NUM_SRC-1:0] mask_all;
   logic [NUM_SRC-1:0] level_all;
   logic [NUM_SRC-1:0] requests;

   always_comb begin
      flags = {pending_i.cmp_rise_flag,
               pending_i.cmp_fall_flag,
               pending_i.pca_wrap_flag | (|pending_i.pca_match_flags),
               pending_i.adc_done_flag,
               pending_i.adc_window_flag,
               pending_i.smbus_flag,
               pending_i.timer2_high_wrap | pending_i.timer2_low_wrap,
               pending_i.uart_rx_done | pending_i.uart_tx_done,
               pending_i.timer1_wrap_flag,
               pending_i.ext1_pending,
               pending_i.timer0_wrap_flag,
               pending_i.ext0_pending};
      mask_all = {cur_reg.extra_mask_reg, cur_reg.int_mask_reg[5:0]};
      level_all = {cur_reg.extra_level_reg, cur_reg.int_level_reg};
      // Gate off means no source at all, whatever the masks say
      requests = flags & mask_all &
                 {NUM_SRC{cur_reg.int_mask_reg[ivpu_pkg::GLOBAL_IRQ_GATE_BIT]}};
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [4:0] winner;
   logic take;

   always_comb begin
      cur_next = cur_reg;
      cur_next.flag_clear = 12'h000;

      // Resampled every clock; an active high routine blocks all, low blocks low
      winner = pick_winner(requests, level_all, !cur_reg.act_lo);
      cur_next.req_valid = winner[4] && !cur_reg.act_hi;
      cur_next.req_idx = winner[3:0];

      // Register writes; the core stalls during the forced call
      if (sfr_i.wr) begin
         unique case (sfr_i.addr)
            ivpu_pkg::INT_MASK_ADDR: begin
               cur_next.int_mask_reg = sfr_i.wdata;
            end
            ivpu_pkg::INT_LEVEL_ADDR: begin
               cur_next.int_level_reg = sfr_i.wdata[5:0];
            end
            ivpu_pkg::EXTRA_MASK_ADDR: begin
               cur_next.extra_mask_reg = sfr_i.wdata[5:0];
            end
            ivpu_pkg::EXTRA_LEVEL_ADDR: begin
               cur_next.extra_level_reg = sfr_i.wdata[5:0];
            end
            default: begin
            end
         endcase
      end

      // Read data reflects register contents one cycle after the address
      unique case (sfr_i.addr)
         ivpu_pkg::INT_MASK_ADDR: cur_next.rdata = cur_reg.int_mask_reg;
         ivpu_pkg::INT_LEVEL_ADDR: cur_next.rdata = {ivpu_pkg::LEVEL_TOP_ONES,
                                                     cur_reg.int_level_reg};
         ivpu_pkg::EXTRA_MASK_ADDR: cur_next.rdata = {ivpu_pkg::EXTRA_MASK_TOP,
                                                      cur_reg.extra_mask_reg};
         ivpu_pkg::EXTRA_LEVEL_ADDR: cur_next.rdata = {ivpu_pkg::LEVEL_TOP_ONES,
                                                       cur_reg.extra_level_reg};
         default: cur_next.rdata = 8'h00;
      endcase

      // A completed return drops the top active level but cannot itself be a call
      // boundary, so at least one more instruction runs first
      take = cur_reg.req_valid && core_i.instr_done && !core_i.is_reti;

      unique case (cur_reg.state)
         ivpu_pkg::ST_IDLE: begin
            if (core_i.instr_done && core_i.is_reti) begin
               if (cur_reg.act_hi) begin
                  cur_next.act_hi = 1'b0;
               end else begin
                  cur_next.act_lo = 1'b0;
               end
            end else if (take) begin
               cur_next.state = ivpu_pkg::ST_CALL;
               cur_next.call_cnt = 3'h0;
               cur_next.vector = vector_of(cur_reg.req_idx);
               if (level_all[cur_reg.req_idx]) begin
                  cur_next.act_hi = 1'b1;
               end else begin
                  cur_next.act_lo = 1'b1;
               end
               cur_next.flag_clear = ivpu_pkg::AUTO_CLEAR_MASK &
                                     (12'h001 << cur_reg.req_idx);
            end
         end
         ivpu_pkg::ST_CALL: begin
            // Sampled requests are discarded until the call ends
            cur_next.req_valid = 1'b0;
            cur_next.call_cnt = cur_reg.call_cnt + 3'h1;
            if (cur_reg.call_cnt == ivpu_pkg::CALL_LAST) begin
               cur_next.state = ivpu_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur_reg.int_mask_reg <= ivpu_pkg::INT_MASK_RESET;
         cur_reg.int_level_reg <= ivpu_pkg::INT_LEVEL_RESET[5:0];
         cur_reg.extra_mask_reg <= ivpu_pkg::EXTRA_MASK_RESET[5:0];
         cur_reg.extra_level_reg <= ivpu_pkg::EXTRA_LEVEL_RESET[5:0];
         cur_reg.req_valid <= 1'b0;
         cur_reg.req_idx <= 4'h0;
         cur_reg.state <= ivpu_pkg::ST_IDLE;
         cur_reg.call_cnt <= 3'h0;
         cur_reg.act_hi <= 1'b0;
         cur_reg.act_lo <= 1'b0;
         cur_reg.rdata <= 8'h00;
         cur_reg.vector <= ivpu_pkg::RESET_VECTOR;
         cur_reg.flag_clear <= 12'h000;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sfr_rdata_o = cur_reg.rdata;
   assign call_o = (cur_reg.state == ivpu_pkg::ST_CALL);
   assign vector_o = cur_reg.vector;
   assign flag_clear_o = cur_reg.flag_clear;
   assign active_high_o = cur_reg.act_hi;
   assign active_low_o = cur_reg.act_lo;

endmodule

// ---- src/ivpu_pkg.sv ----
// Shared constants and carrier types of the interrupt vector and priority unit
package ivpu_pkg;

   // ----------------------------------------------------------------
   // Register addresses on the special register port
   // ----------------------------------------------------------------
   localparam logic [7:0] INT_MASK_ADDR = 8'hA8;
   localparam logic [7:0] INT_LEVEL_ADDR = 8'hB8;
   localparam logic [7:0] EXTRA_MASK_ADDR = 8'hE6;
   localparam logic [7:0] EXTRA_LEVEL_ADDR = 8'hF6;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int GLOBAL_IRQ_GATE_BIT = 7;
   localparam int SPARE_USER_FLAG_BIT = 6;
   localparam int SOURCE_BITS = 6;
   localparam logic [7:0] INT_MASK_RESET = 8'h00;
   localparam logic [7:0] INT_LEVEL_RESET = 8'hC0;
   localparam logic [7:0] EXTRA_MASK_RESET = 8'h00;
   localparam logic [7:0] EXTRA_LEVEL_RESET = 8'hC0;
   localparam logic [1:0] LEVEL_TOP_ONES = 2'h3;
   localparam logic [1:0] EXTRA_MASK_TOP = 2'h0;

   // ----------------------------------------------------------------
   // Sources, vectors and timing
   // ----------------------------------------------------------------
   localparam int NUM_SOURCES = 12;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] FIRST_VECTOR = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;
   // Sources whose flag the hardware clears on vectoring: ext0, timer0, ext1, timer1
   localparam logic [11:0] AUTO_CLEAR_MASK = 12'h00F;
   localparam int CALL_CYCLES = 4;
   localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ext0_pending;
      logic timer0_wrap_flag;
      logic ext1_pending;
      logic timer1_wrap_flag;
      logic uart_rx_done;
      logic uart_tx_done;
      logic timer2_low_wrap;
      logic timer2_high_wrap;
      logic smbus_flag;
      logic adc_window_flag;
      logic adc_done_flag;
      logic pca_wrap_flag;
      logic [2:0] pca_match_flags;
      logic cmp_fall_flag;
      logic cmp_rise_flag;
   } pending_type;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      logic instr_done;
      logic is_reti;
   } core_status_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CALL = 2'b10
   } call_state_type;

endpackage

// ---- tb/core_model.sv ----
// Behavioural core sequencer pacing instruction boundaries
`timescale 1ns/1ns
module core_model (
   input wire logic clk_i, // Clock
   input wire logic call_i, // Forced call running
   input wire logic reti_i, // Finishing instructions are returns
   input wire logic [3:0] len_i, // Cycles per instruction
   output ivpu_pkg::core_status_type core_o // Boundary status
);
   logic [3:0] cnt = 4'h1;
   logic done;
   // Stalls during the forced call, so no boundary is offered then
   assign done = !call_i && cnt >= len_i;
   assign core_o = '{instr_done: done, is_reti: done && reti_i};
   always @(posedge clk_i) begin
      if (call_i || done) cnt <= 4'h1;
      else cnt <= cnt + 4'h1;
   end
endmodule

// ---- tb/ivpu_assertions.sv ----
// Port checker for the interrupt vector and priority unit
`timescale 1ns/1ns
module ivpu_checker (
   input wire logic clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire ivpu_pkg::sfr_req_type sfr_i, // Register port
   input wire ivpu_pkg::core_status_type core_i, // Core status
   input wire logic [7:0] sfr_rdata_o, // Read data
   input wire logic call_o, // Forced call
   input wire logic [15:0] vector_o, // Target
   input wire logic [11:0] flag_clear_o, // Clears
   input wire logic active_high_o // High active
);
   // ------------------------------
   // Gate copy taken from writes
   // ------------------------------
   logic gate_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) gate_q <= 1'b0;
      else if (sfr_i.wr && sfr_i.addr == ivpu_pkg::INT_MASK_ADDR) gate_q <= sfr_i.wdata[7];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_burst; call_o [*4] ##1 !call_o; endsequence
   sequence s_hret; core_i.instr_done && core_i.is_reti && active_high_o && !call_o; endsequence
   property p_len; $rose(call_o) |-> s_burst; endproperty
   a_len: assert property (p_len) else $error("call length");
   property p_take;
      $rose(call_o) |-> $past(core_i.instr_done) && !$past(core_i.is_reti);
   endproperty
   a_take: assert property (p_take) else $error("call off boundary");
   property p_high; $rose(call_o) |-> !$past(active_high_o); endproperty
   a_high: assert property (p_high) else $error("high preempted");
   property p_clr; |flag_clear_o |-> $rose(call_o) && flag_clear_o[11:4] == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("bad clear");
   property p_vec; $rose(call_o) |-> vector_o[2:0] == 3'h3 && vector_o <= 16'h005B; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_hold; !$rose(call_o) |-> $stable(vector_o); endproperty
   a_hold: assert property (p_hold) else $error("vector moved");
   property p_gate; !gate_q && !$past(gate_q) && !$past(gate_q, 2) |-> !$rose(call_o); endproperty
   a_gate: assert property (p_gate) else $error("gate ignored");
   property p_top;
      $past(rst_n_i) && ($past(sfr_i.addr) == ivpu_pkg::INT_LEVEL_ADDR ||
         $past(sfr_i.addr) == ivpu_pkg::EXTRA_LEVEL_ADDR) |-> sfr_rdata_o[7:6] == 2'h3;
   endproperty
   a_top: assert property (p_top) else $error("level top bits");
   property p_xm;
      $past(rst_n_i) && $past(sfr_i.addr) == ivpu_pkg::EXTRA_MASK_ADDR |->
         sfr_rdata_o[7:6] == 2'h0;
   endproperty
   a_xm: assert property (p_xm) else $error("mask top bits");
   property p_ret; s_hret |=> !active_high_o; endproperty
   a_ret: assert property (p_ret) else $error("return kept high");
endmodule
bind interrupt_vector_priority_unit ivpu_checker u_ivpu_checker (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .sfr_i(sfr_i), .core_i(core_i), .sfr_rdata_o(sfr_rdata_o),
   .call_o(call_o), .vector_o(vector_o), .flag_clear_o(flag_clear_o),
   .active_high_o(active_high_o));

// ---- tb/tb_top.sv ----
// Self-checking bench for the interrupt vector and priority unit
`timescale 1ns/1ns
module tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   ivpu_pkg::pending_type pending_i = '0;
   ivpu_pkg::sfr_req_type sfr_i = '0;
   ivpu_pkg::core_status_type core_i;
   logic [7:0] sfr_rdata_o;
   logic call_o, active_high_o, active_low_o;
   logic [15:0] vector_o;
   logic [11:0] flag_clear_o;
   logic reti = 1'b0;
   logic [3:0] len = 4'h1;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   always #5 clk_i = ~clk_i;
   interrupt_vector_priority_unit u_interrupt_vector_priority_unit (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .pending_i(pending_i), .sfr_i(sfr_i), .core_i(core_i),
      .sfr_rdata_o(sfr_rdata_o), .call_o(call_o), .vector_o(vector_o),
      .flag_clear_o(flag_clear_o), .active_high_o(active_high_o), .active_low_o(active_low_o));
   core_model u_core_model (.clk_i(clk_i), .call_i(call_o), .reti_i(reti), .len_i(len),
      .core_o(core_i));
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (exp !== got) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_i = '{a, 1'b1, d};
      @(negedge clk_i);
      sfr_i.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_i);
      sfr_i.addr = a;
      @(negedge clk_i);
      chk("rdata", 16'(e), 16'(sfr_rdata_o));
   endtask
   task automatic wait_call(input int lim, output int n);
      n = 0;
      while (call_o !== 1'b1 && n < lim) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   // Checks target and auto clear at the first call cycle, then lets the call finish
   task automatic take(input int lim, input logic [15:0] ev, output int n);
      wait_call(lim, n);
      chk("vector", ev, vector_o);
      chk("clear", (ev < 16'h0020) ? 16'(1 << ev[5:3]) : 16'h0000, 16'(flag_clear_o));
      repeat (4) @(negedge clk_i);
   endtask
   task automatic do_ret();
      int k;
      reti = 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (!(core_i.instr_done && core_i.is_reti) && k < 40);
      @(negedge clk_i);
      reti = 1'b0;
   endtask
   // Picks one of a shared source's flags at random
   function automatic ivpu_pkg::pending_type flag_of(input int i);
      int pos[12] = '{16, 15, 14, 13, 12, 10, 8, 7, 6, 5, 1, 0};
      int alt[12] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 3, 0, 0};
      logic [$bits(ivpu_pkg::pending_type)-1:0] v;
      v = '0;
      v[pos[i] - int'($urandom_range(alt[i], 0))] = 1'b1;
      return ivpu_pkg::pending_type'(v);
   endfunction
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      logic [7:0] ad [5];
      logic [7:0] km [5];
      logic [7:0] fo [5];
      logic [7:0] d;
      int n;
      ad = '{ivpu_pkg::INT_MASK_ADDR, ivpu_pkg::INT_LEVEL_ADDR, ivpu_pkg::EXTRA_MASK_ADDR,
         ivpu_pkg::EXTRA_LEVEL_ADDR, 8'h55};
      km = '{8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h00};
      fo = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00};
      void'($urandom(90));
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      for (int j = 0; j < 5; j++) begin
         d = 8'($urandom);
         rd(ad[j], fo[j]);
         wr(ad[j], d);
         rd(ad[j], (d & km[j]) | fo[j]);
      end
      wr(ad[0], 8'hFF);
      wr(ad[1], 8'h00);
      wr(ad[2], 8'hFF);
      wr(ad[3], 8'h00);
      for (int i = 0; i < 12; i++) begin
         pending_i = flag_of(i);
         take(10, ivpu_pkg::FIRST_VECTOR + ivpu_pkg::VECTOR_STEP * 16'(i),
              n);
         chk("latency", 16'h0002, 16'(n));
         pending_i = '0;
         do_ret();
      end
      wr(ad[0], 8'h7F);
      pending_i = flag_of(0);
      wait_call(20, n);
      chk("gate off", 16'h0000, 16'(call_o));
      wr(ad[0], 8'h80);
      wait_call(20, n);
      chk("mask off", 16'h0000, 16'(call_o));
      wr(ad[0], 8'hFF);
      take(10, 16'h0003, n);
      pending_i = '0;
      do_ret();
      wr(ad[1], 8'h20);
      wr(ad[3], 8'h01);
      pending_i = flag_of(1) | flag_of(3);
      take(10, 16'h000B, n);
      pending_i = flag_of(3) | flag_of(5);
      take(10, 16'h002B, n);
      chk("high active", 16'h0001, 16'(active_high_o));
      pending_i = flag_of(3) | flag_of(6);
      wait_call(20, n);
      chk("held by high", 16'h0000, 16'(call_o));
      do_ret();
      take(10, 16'h0033, n);
      pending_i = flag_of(3);
      do_ret();
      wait_call(20, n);
      chk("held by low", 16'h0000, 16'(call_o));
      len = 4'h5;
      do_ret();
      len = 4'h8;
      take(10, 16'h001B, n);
      chk("worst latency", 16'h0008, 16'(n));
      pending_i = '0;
      len = 4'h1;
      do_ret();
      chk("no routine", 16'h0000, 16'({active_high_o, active_low_o}));
      give_verdict();
   end
endmodule
